// [common/cdg_pkg.sv]
// package: register map, field layout and gain tables of the divider and gain bank
package cdg_pkg;

   // ===========================================================
   // bus map (byte addresses, one word per register)
   localparam logic [7:0] DIV_OFS   = 8'h00;
   localparam logic [7:0] GAIN_OFS  = 8'h04;
   localparam logic [7:0] ADC_OFS   = 8'h08;
   localparam logic [7:0] DAC_OFS   = 8'h0C;
   localparam logic [7:0] SIDE_OFS  = 8'h10;
   localparam logic [7:0] RATIO_OFS = 8'h14;
   localparam int         ADDR_W    = 8;
   localparam int         TRANS_ACT = 1;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   localparam logic       RESP_OKAY = 1'h0;

   // ===========================================================
   // field layout
   localparam int SEL_BIT = 7;
   localparam int SUB_LSB = 6;
   localparam int M_W     = 7;
   localparam int N_LSB   = 3;
   localparam int N_W     = 4;
   localparam int P_W     = 3;
   localparam int PGA_W   = 6;
   localparam int AST_LSB = 3;
   localparam int ST_W    = 3;
   localparam int RATIO_W = 19;
   localparam logic [1:0] SUB_ADC  = 2'h0;
   localparam logic [1:0] SUB_DAC  = 2'h1;
   localparam logic [1:0] SUB_SIDE = 2'h2;

   // ===========================================================
   // reset values
   localparam logic [7:0] DIV_RST  = 8'h00;
   localparam logic [6:0] M_RST    = 7'h00;
   localparam logic [3:0] N_RST    = 4'h0;
   localparam logic [2:0] P_RST    = 3'h0;
   localparam logic [7:0] ADC_RST  = 8'h00;
   localparam logic [7:0] DAC_RST  = 8'h40;
   localparam logic [7:0] SIDE_RST = 8'h80;

   // ===========================================================
   // frame-sync scale and gain tables, gains in half-dB units
   localparam logic [18:0] FS_SCALE      = 19'h00010;
   localparam logic [5:0]  PGA_STEP_LAST = 6'h1B;
   localparam logic [5:0]  PGA_CODE_42   = 6'h1C;
   localparam logic [5:0]  PGA_CODE_48   = 6'h1D;
   localparam logic [5:0]  PGA_CODE_54   = 6'h1E;
   localparam logic [5:0]  PGA_MUTE      = 6'h1F;
   localparam logic [7:0]  PGA_HDB_STEP  = 8'h03;
   localparam logic [7:0]  PGA_HDB_42    = 8'h54;
   localparam logic [7:0]  PGA_HDB_48    = 8'h60;
   localparam logic [7:0]  PGA_HDB_54    = 8'h6C;
   localparam logic [2:0]  ST_MUTE       = 3'h7;
   localparam logic [7:0]  ST_HDB_BASE   = 8'hEE;
   localparam logic [7:0]  ST_HDB_STEP   = 8'h06;

   // ===========================================================
   // carriers
   typedef struct packed {
      logic             sel;
      logic             write;
      logic [ADDR_W-1:0] addr;
   } cdg_aph_t;

   typedef struct packed {
      logic [7:0]    div;
      logic [M_W-1:0] m;
      logic [N_W-1:0] n;
      logic [P_W-1:0] p;
      logic [7:0]    adc;
      logic [7:0]    dac;
      logic [7:0]    side;
   } cdg_regs_t;

   typedef struct packed {
      logic       mute;
      logic [7:0] hdb;
   } cdg_gain_t;

   typedef struct packed {
      cdg_gain_t adc;
      cdg_gain_t dac;
      cdg_gain_t ast;
      cdg_gain_t dst;
   } cdg_gains_t;

endpackage

// [rtl/cdg_fs_div.sv]
// frame-sync divider: one pulse every ratio_i clocks
`timescale 1ns/1ps
`default_nettype none
module cdg_fs_div (
   input  wire logic                        clk_i,
   input  wire logic                        reset_i,
   input  wire logic [cdg_pkg::RATIO_W-1:0] ratio_i,
   output var  logic                        fs_o
);

   localparam int RW = cdg_pkg::RATIO_W;

   logic [RW-1:0] count;
   logic [RW-1:0] next_count;
   logic          next_fs;

   // ===========================================================
   // counter
   // a ratio shrinking below the count wraps at once, so no long stall
   always_comb begin
      next_count = RW'(count + 1'b1);
      next_fs    = 1'b0;
      if (count >= RW'(ratio_i - 1'b1)) begin
         next_count = '0;
         next_fs    = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count <= '0;
         fs_o  <= 1'b0;
      end else begin
         count <= next_count;
         fs_o  <= next_fs;
      end
   end

   // ===========================================================
   // checks
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_fs_wrap: assert property (
      fs_o |-> count == '0 && $past(count) >= RW'($past(ratio_i) - 1'b1))
      else $error("frame pulse without counter wrap");

endmodule // cdg_fs_div
`default_nettype wire

// [rtl/cdg_regs_top.sv]
// divider and gain register bank behind an AHB-Lite slave port
`timescale 1ns/1ps
`default_nettype none
module cdg_regs_top (
   input  wire logic                      CLK_I,
   input  wire logic                      RESET_I,
   input  wire logic                      HSEL_I,
   input  wire logic [31:0]               HADDR_I,
   input  wire logic [1:0]                HTRANS_I,
   input  wire logic                      HWRITE_I,
   input  wire logic [2:0]                HSIZE_I,
   input  wire logic [31:0]               HWDATA_I,
   input  wire logic                      HREADY_I,
   output var  logic [31:0]               HRDATA_O,
   output var  logic                      HREADYOUT_O,
   output var  logic                      HRESP_O,
   output var  logic                      FS_O,
   output var  cdg_pkg::cdg_gains_t       GAINS_O
);

   localparam int RW = cdg_pkg::RATIO_W;

   // ===========================================================
   // gain decoders
   // codes above 31 are undefined; they are treated as mute for safety
   function automatic cdg_pkg::cdg_gain_t dec_pga(
      input logic [cdg_pkg::PGA_W-1:0] code,
      input logic                      neg
   );
      cdg_pkg::cdg_gain_t g;
      logic [7:0]         mag;
      mag    = 8'h00;
      g.mute = (code >= cdg_pkg::PGA_MUTE);
      if (code <= cdg_pkg::PGA_STEP_LAST) begin
         mag = 8'({2'h0, code} * cdg_pkg::PGA_HDB_STEP);
      end else if (code == cdg_pkg::PGA_CODE_42) begin
         mag = cdg_pkg::PGA_HDB_42;
      end else if (code == cdg_pkg::PGA_CODE_48) begin
         mag = cdg_pkg::PGA_HDB_48;
      end else if (code == cdg_pkg::PGA_CODE_54) begin
         mag = cdg_pkg::PGA_HDB_54;
      end
      g.hdb = neg ? 8'(8'h00 - mag) : mag;
      return g;
   endfunction

   function automatic cdg_pkg::cdg_gain_t dec_st(
      input logic [cdg_pkg::ST_W-1:0] code
   );
      cdg_pkg::cdg_gain_t g;
      g.mute = (code == cdg_pkg::ST_MUTE);
      g.hdb  = g.mute ? 8'h00
               : 8'(cdg_pkg::ST_HDB_BASE - 8'({5'h0, code} * cdg_pkg::ST_HDB_STEP));
      return g;
   endfunction

   // ===========================================================
   // address phase capture
   cdg_pkg::cdg_aph_t aph;
   cdg_pkg::cdg_aph_t next_aph;
   logic              rd_req;

   always_comb begin
      next_aph.sel   = HSEL_I & HTRANS_I[cdg_pkg::TRANS_ACT] & HREADY_I;
      next_aph.write = HWRITE_I & (HSIZE_I == cdg_pkg::SIZE_WORD);
      next_aph.addr  = HADDR_I[cdg_pkg::ADDR_W-1:0];
      rd_req         = next_aph.sel & ~HWRITE_I;
   end

   // ===========================================================
   // register writes, taken in the data phase
   cdg_pkg::cdg_regs_t r;
   cdg_pkg::cdg_regs_t next_r;
   logic               wr_en;

   always_comb begin
      next_r = r;
      wr_en  = aph.sel & aph.write;
      if (wr_en) begin
         unique case (aph.addr)
            cdg_pkg::DIV_OFS: begin
               next_r.div = HWDATA_I[7:0];
               if (HWDATA_I[cdg_pkg::SEL_BIT]) begin
                  next_r.m = HWDATA_I[cdg_pkg::M_W-1:0];
               end else begin
                  next_r.n = HWDATA_I[cdg_pkg::N_LSB +: cdg_pkg::N_W];
                  next_r.p = HWDATA_I[cdg_pkg::P_W-1:0];
               end
            end
            cdg_pkg::GAIN_OFS: begin
               unique case (HWDATA_I[cdg_pkg::SUB_LSB +: 2])
                  cdg_pkg::SUB_ADC:  next_r.adc  = HWDATA_I[7:0];
                  cdg_pkg::SUB_DAC:  next_r.dac  = HWDATA_I[7:0];
                  cdg_pkg::SUB_SIDE: next_r.side = HWDATA_I[7:0];
                  default: ;
               endcase
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         r.div  <= cdg_pkg::DIV_RST;
         r.m    <= cdg_pkg::M_RST;
         r.n    <= cdg_pkg::N_RST;
         r.p    <= cdg_pkg::P_RST;
         r.adc  <= cdg_pkg::ADC_RST;
         r.dac  <= cdg_pkg::DAC_RST;
         r.side <= cdg_pkg::SIDE_RST;
      end else begin
         r <= next_r;
      end
   end

   // ===========================================================
   // divider ratio and gain decode, updated with the registers
   logic [7:0]          next_m_val;
   logic [4:0]          next_n_val;
   logic [3:0]          next_p_val;
   logic [RW-1:0]       ratio;
   logic [RW-1:0]       next_ratio;
   cdg_pkg::cdg_gains_t next_gains;

   always_comb begin
      // an all-zero code stands for the largest divider
      next_m_val = {~|next_r.m, next_r.m};
      next_n_val = {~|next_r.n, next_r.n};
      next_p_val = {~|next_r.p, next_r.p};
      next_ratio = RW'({11'h0, next_m_val} * {14'h0, next_n_val} * {15'h0, next_p_val}
                       * cdg_pkg::FS_SCALE);
      next_gains.adc = dec_pga(next_r.adc[cdg_pkg::PGA_W-1:0], 1'b0);
      next_gains.dac = dec_pga(next_r.dac[cdg_pkg::PGA_W-1:0], 1'b1);
      next_gains.ast = dec_st(next_r.side[cdg_pkg::AST_LSB +: cdg_pkg::ST_W]);
      next_gains.dst = dec_st(next_r.side[cdg_pkg::ST_W-1:0]);
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         ratio   <= '0;
         GAINS_O <= '0;
      end else begin
         ratio   <= next_ratio;
         GAINS_O <= next_gains;
      end
   end

   // ===========================================================
   // bus answers
   // read data is taken from the next register values so that a read
   // right behind a write sees the new value with no wait state
   logic [31:0] next_hrdata;

   always_comb begin
      next_hrdata = 32'h00000000;
      if (rd_req) begin
         unique case (next_aph.addr)
            cdg_pkg::DIV_OFS:   next_hrdata = {24'h000000, next_r.div};
            cdg_pkg::ADC_OFS:   next_hrdata = {24'h000000, next_r.adc};
            cdg_pkg::DAC_OFS:   next_hrdata = {24'h000000, next_r.dac};
            cdg_pkg::SIDE_OFS:  next_hrdata = {24'h000000, next_r.side};
            cdg_pkg::RATIO_OFS: next_hrdata = {13'h0000, next_ratio};
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         aph         <= '0;
         HRDATA_O    <= 32'h00000000;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= cdg_pkg::RESP_OKAY;
      end else begin
         aph         <= next_aph;
         HRDATA_O    <= next_hrdata;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= cdg_pkg::RESP_OKAY;
      end
   end

   // ===========================================================
   // frame-sync generator
   cdg_fs_div u_fs_div (
      .clk_i   (CLK_I),
      .reset_i (RESET_I),
      .ratio_i (ratio),
      .fs_o    (FS_O)
   );

   // ===========================================================
   // checks
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RESET_I);

   sequence s_wr(logic [7:0] a);
      aph.sel && aph.write && aph.addr == a;
   endsequence

   sequence s_div_m;
      s_wr(cdg_pkg::DIV_OFS) ##0 HWDATA_I[7];
   endsequence

   sequence s_div_np;
      s_wr(cdg_pkg::DIV_OFS) ##0 !HWDATA_I[7];
   endsequence

   sequence s_gain(logic [1:0] sub);
      s_wr(cdg_pkg::GAIN_OFS) ##0 HWDATA_I[7:6] == sub;
   endsequence

   // ratio holds its reset value for one edge after reset is released
   a_ratio_product: assert property (
      !$past(RESET_I) |->
      ratio == RW'({11'h0, r.m == 7'h00 ? 8'h80 : {1'b0, r.m}}
                   * {14'h0, r.n == 4'h0 ? 5'h10 : {1'b0, r.n}}
                   * {15'h0, r.p == 3'h0 ? 4'h8 : {1'b0, r.p}} * 19'h00010))
      else $error("ratio is not 16*M*N*P");

   a_m_load: assert property (
      s_div_m |=> r.m == $past(HWDATA_I[6:0]) && r.div == $past(HWDATA_I[7:0]))
      else $error("M not loaded from D6-D0");

   a_n_load: assert property (
      s_div_np |=> r.n == $past(HWDATA_I[6:3]))
      else $error("N not loaded from D6-D3");

   a_p_load: assert property (
      s_div_np |=> r.p == $past(HWDATA_I[2:0]))
      else $error("P not loaded from D2-D0");

   a_sel_keeps: assert property (
      s_div_m |=> $stable(r.n) && $stable(r.p))
      else $error("M write disturbed N or P");

   a_sel_keepm: assert property (
      s_div_np |=> $stable(r.m))
      else $error("N/P write disturbed M");

   a_gain_route: assert property (
      s_gain(2'h1) |=> r.dac == $past(HWDATA_I[7:0]) && $stable(r.adc)
                       && $stable(r.side))
      else $error("gain write went to the wrong sub-register");

   a_adc_route: assert property (
      s_gain(2'h0) |=> r.adc == $past(HWDATA_I[7:0]) && $stable(r.dac)
                       && $stable(r.side))
      else $error("ADC gain write went to the wrong sub-register");

   a_side_route: assert property (
      s_gain(2'h2) |=> r.side == $past(HWDATA_I[7:0]) && $stable(r.adc)
                       && $stable(r.dac))
      else $error("sidetone write went to the wrong sub-register");

   a_adc_step: assert property (
      r.adc[5:0] <= 6'h1B |-> !GAINS_O.adc.mute
                             && GAINS_O.adc.hdb == 8'(r.adc[5:0] * 8'h03))
      else $error("ADC step gain wrong");

   a_adc_top: assert property (
      r.adc[5:0] >= 6'h1C && r.adc[5:0] <= 6'h1F |->
      GAINS_O.adc.mute == (r.adc[5:0] == 6'h1F)
      && GAINS_O.adc.hdb == (r.adc[5:0] == 6'h1C ? 8'h54 : r.adc[5:0] == 6'h1D ? 8'h60
                             : r.adc[5:0] == 6'h1E ? 8'h6C : 8'h00))
      else $error("ADC top codes wrong");

   a_dac_step: assert property (
      r.dac[5:0] <= 6'h1B |-> GAINS_O.dac.hdb == 8'(8'h00 - 8'(r.dac[5:0] * 8'h03)))
      else $error("DAC step attenuation wrong");

   a_dac_top: assert property (
      r.dac[5:0] >= 6'h1C && r.dac[5:0] <= 6'h1F |->
      GAINS_O.dac.mute == (r.dac[5:0] == 6'h1F)
      && GAINS_O.dac.hdb == (r.dac[5:0] == 6'h1C ? 8'hAC : r.dac[5:0] == 6'h1D ? 8'hA0
                             : r.dac[5:0] == 6'h1E ? 8'h94 : 8'h00))
      else $error("DAC top codes wrong");

   // gains hold their reset value for one edge after reset is released
   a_ast_gain: assert property (
      !$past(RESET_I) && r.side[5:3] != 3'h7 |->
      GAINS_O.ast.hdb == 8'(8'h00 - 8'h12 - 8'(r.side[5:3] * 8'h06)))
      else $error("analog sidetone gain wrong");

   a_dst_mute: assert property (
      GAINS_O.dst.mute |-> r.side[2:0] == 3'h7 && GAINS_O.dst.hdb == 8'h00)
      else $error("digital sidetone mute wrong");

endmodule // cdg_regs_top
`default_nettype wire

// [sim/cdg_regs_top_bench.sv]
// self-checking bench for the divider and gain register bank
`timescale 1ns/1ps
`default_nettype none
module cdg_regs_top_bench;
   // ===========================================================
   // signals and design
   localparam int TIMEOUT = 20000;
   logic                clk_i;
   logic                reset_i;
   logic                hsel;
   logic [31:0]         haddr;
   logic [1:0]          htrans;
   logic                hwrite;
   logic [2:0]          hsize;
   logic [31:0]         hwdata;
   logic [31:0]         hrdata;
   logic                hreadyout;
   logic                hresp;
   logic                fs;
   cdg_pkg::cdg_gains_t gains;
   int                  fail_count;
   int                  compares;
   int                  cycle_count;
   int                  m;
   int                  n;
   int                  p;
   logic [31:0]         rd;
   logic [7:0]          div_tab [10] = '{8'h81, 8'hFF, 8'h09, 8'h7F, 8'h80, 8'h00,
                                         8'h82, 8'h1C, 8'h81, 8'h09};

   cdg_regs_top u_cdg_regs_top (
      .CLK_I       (clk_i),
      .RESET_I     (reset_i),
      .HSEL_I      (hsel),
      .HADDR_I     (haddr),
      .HTRANS_I    (htrans),
      .HWRITE_I    (hwrite),
      .HSIZE_I     (hsize),
      .HWDATA_I    (hwdata),
      .HREADY_I    (hreadyout),
      .HRDATA_O    (hrdata),
      .HREADYOUT_O (hreadyout),
      .HRESP_O     (hresp),
      .FS_O        (fs),
      .GAINS_O     (gains)
   );

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // ===========================================================
   // verdict and hang guard
   task automatic complete_run();
      if (fail_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge clk_i) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == TIMEOUT) begin
         fail_count = fail_count + 1;
         complete_run();
      end
   end

   // ===========================================================
   // compares
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_gain(input cdg_pkg::cdg_gain_t got, input cdg_pkg::cdg_gain_t exp);
      compares = compares + 1;
      if (got !== exp) begin
         fail_count = fail_count + 1;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ===========================================================
   // expected gains in half-dB units
   function automatic cdg_pkg::cdg_gain_t pga_exp(input int code, input logic neg);
      cdg_pkg::cdg_gain_t g;
      logic [7:0]         h;
      h = (code <= 27) ? 8'(3 * code) : (code == 28) ? 8'h54 : (code == 29) ? 8'h60 :
          (code == 30) ? 8'h6C : 8'h00;
      g.mute = (code == 31);
      g.hdb  = neg ? 8'(-h) : h;
      return g;
   endfunction

   function automatic cdg_pkg::cdg_gain_t st_exp(input int code);
      cdg_pkg::cdg_gain_t g;
      g.mute = (code == 7);
      g.hdb  = (code == 7) ? 8'h00 : 8'(-18 - 6 * code);
      return g;
   endfunction

   // ===========================================================
   // bus cycles: address phase held until hready, then data phase
   task automatic ahb_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                           output logic [31:0] rdat);
      // called mid-cycle after a check: move to the next rising edge first
      if (clk_i == 1'b0) begin
         @(posedge clk_i);
      end
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      hsize  <= cdg_pkg::SIZE_WORD;
      do begin
         @(posedge clk_i);
      end while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      // read data is taken at the edge that ends the data phase
      do begin
         @(posedge clk_i);
         rdat = hrdata;
      end while (hreadyout !== 1'b1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] dummy;
      ahb_xfer(a, 1'b1, {24'h000000, d}, dummy);
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] v;
      ahb_xfer(a, 1'b0, 32'h00000000, v);
      check_word(v, exp);
   endtask

   // waits for one pulse, checks that it is one clock wide, then times the next one
   task automatic fs_period(input int exp);
      int k;
      k = 0;
      do begin
         @(negedge clk_i);
         k++;
      end while (fs !== 1'b1 && k < 1000);
      @(negedge clk_i);
      check_word({31'h0, fs}, 32'h00000000);
      k = 1;
      while (fs !== 1'b1 && k < 1000) begin
         @(negedge clk_i);
         k++;
      end
      check_word(k, exp);
   endtask

   // ===========================================================
   // main sequence
   initial begin
      fail_count  = 0;
      compares    = 0;
      cycle_count = 0;
      reset_i     = 1'b1;
      hsel        = 1'b0;
      haddr       = 32'h00000000;
      htrans      = 2'h0;
      hwrite      = 1'b0;
      hsize       = 3'h2;
      hwdata      = 32'h00000000;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      @(negedge clk_i);
      check_gain(gains.adc, pga_exp(0, 1'b0));
      check_gain(gains.dac, pga_exp(0, 1'b1));
      check_gain(gains.ast, st_exp(0));
      check_gain(gains.dst, st_exp(0));
      @(posedge clk_i);
      rd_check(cdg_pkg::DIV_OFS, 32'h00000000);
      rd_check(cdg_pkg::DAC_OFS, 32'h00000040);
      rd_check(cdg_pkg::SIDE_OFS, 32'h00000080);
      rd_check(cdg_pkg::RATIO_OFS, 32'h00040000);
      rd_check(8'h18, 32'h00000000);
      rd_check(cdg_pkg::GAIN_OFS, 32'h00000000);
      wr(8'h18, 8'h55);
      rd_check(cdg_pkg::DIV_OFS, 32'h00000000);
      // divider writes, model tracks M, N and P separately
      m = 128;
      n = 16;
      p = 8;
      for (int i = 0; i < 10; i++) begin
         wr(cdg_pkg::DIV_OFS, div_tab[i]);
         if (div_tab[i][7]) begin
            m = (div_tab[i][6:0] == 7'h00) ? 128 : int'(div_tab[i][6:0]);
         end else begin
            n = (div_tab[i][6:3] == 4'h0) ? 16 : int'(div_tab[i][6:3]);
            p = (div_tab[i][2:0] == 3'h0) ? 8 : int'(div_tab[i][2:0]);
         end
         rd_check(cdg_pkg::DIV_OFS, {24'h000000, div_tab[i]});
         rd_check(cdg_pkg::RATIO_OFS, 16 * m * n * p);
         if (i == 7) begin
            fs_period(384);
         end
      end
      fs_period(16);
      // codes 0 to 31 of the ADC and DAC fields and all sidetone codes, through the shared address
      for (int i = 0; i < 32; i++) begin
         wr(cdg_pkg::GAIN_OFS, 8'(i));
         @(negedge clk_i);
         check_gain(gains.adc, pga_exp(i, 1'b0));
         rd_check(cdg_pkg::ADC_OFS, i);
         wr(cdg_pkg::GAIN_OFS, 8'h40 | 8'(i));
         @(negedge clk_i);
         check_gain(gains.dac, pga_exp(i, 1'b1));
         rd_check(cdg_pkg::DAC_OFS, 32'h40 | i);
      end
      for (int i = 0; i < 8; i++) begin
         wr(cdg_pkg::GAIN_OFS, 8'h80 | 8'(i << 3) | 8'(7 - i));
         @(negedge clk_i);
         check_gain(gains.ast, st_exp(i));
         check_gain(gains.dst, st_exp(7 - i));
      end
      // select code 11 picks no sub-register
      wr(cdg_pkg::GAIN_OFS, 8'hC5);
      @(negedge clk_i);
      check_gain(gains.adc, pga_exp(31, 1'b0));
      rd_check(cdg_pkg::ADC_OFS, 32'h0000001F);
      rd_check(cdg_pkg::DAC_OFS, 32'h0000005F);
      rd_check(cdg_pkg::SIDE_OFS, 32'h000000B8);
      check_word({31'h0, hresp}, 32'h00000000);
      complete_run();
   end
endmodule // cdg_regs_top_bench
`default_nettype wire
